/* File: design/bmi_pkg.sv */
`default_nettype none
// ============================================================
// Shared constants for the measurement integrator
package bmi_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int FAST_BASE_NS   = 366000;
  localparam int FAST_BASE_CYC  = FAST_BASE_NS / CLK_PERIOD_NS;
  localparam int SLOW_PERIOD_MS = 250;
  localparam int SLOW_CYC       = SLOW_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SECOND_NS      = 1000000000;
  localparam int SECOND_CYC     = SECOND_NS / CLK_PERIOD_NS;
  localparam int LP_SHIFT       = 4;
  localparam int SLOW_SHIFT     = 8;

  // Register word indices
  localparam logic [4:0] REG_CTRL      = 5'h00;
  localparam logic [4:0] REG_CELL_MAP  = 5'h01;
  localparam logic [4:0] REG_PROT_EN   = 5'h02;
  localparam logic [4:0] REG_PROT_AUTO = 5'h03;
  localparam logic [4:0] REG_CELL_TH   = 5'h04;
  localparam logic [4:0] REG_DIE_TH    = 5'h05;
  localparam logic [4:0] REG_FAULT     = 5'h06;
  localparam logic [4:0] REG_CMD       = 5'h07;
  localparam logic [4:0] REG_TRIM0     = 5'h08;
  localparam logic [4:0] REG_PWM       = 5'h0c;
  localparam logic [4:0] REG_CELL0     = 5'h10;
  localparam logic [4:0] REG_STACK     = 5'h17;
  localparam logic [4:0] REG_DIE_TEMP  = 5'h18;
  localparam logic [4:0] REG_TS        = 5'h19;
  localparam logic [4:0] REG_CURRENT   = 5'h1a;
  localparam logic [4:0] REG_FAST_RAW  = 5'h1b;
  localparam logic [4:0] REG_CHG_LO    = 5'h1c;
  localparam logic [4:0] REG_CHG_HI    = 5'h1d;
  localparam logic [4:0] REG_ACC_TIME  = 5'h1e;
  localparam logic [4:0] REG_STATUS    = 5'h1f;

  // Control register fields
  localparam int CTRL_GENERAL_ANALOG_INPUT    = 0;
  localparam int CTRL_RATE_LSB = 1;
  localparam int CTRL_LOWPWR   = 3;
  localparam int CTRL_PARALLEL = 4;
  localparam int CTRL_OT_SHDN  = 5;
  localparam int CTRL_CHG_ON   = 6;
  localparam int CTRL_DSG_ON   = 7;
  localparam int CTRL_PWM_EN   = 8;

  // Trim slots: offset in [15:0], gain in [31:16], unity gain 0x4000
  localparam int TRIM_CELL  = 0;
  localparam int TRIM_STACK = 1;
  localparam int TRIM_DIE   = 2;
  localparam int TRIM_CUR   = 3;
  localparam logic [31:0] TRIM_RST = 32'h4000_0000;

  // Reset values
  localparam logic [8:0]  CTRL_RST     = 9'h000;
  localparam logic [6:0]  CELL_MAP_RST = 7'h7f;
  localparam logic [31:0] CELL_TH_RST  = 32'h0bb8_1068;
  localparam logic [15:0] DIE_TH_RST   = 16'h0d48;

  // Fault bits and which FET each one blocks
  localparam int F_UV = 0;
  localparam int F_OV = 1;
  localparam int F_OCC = 2;
  localparam int F_OCD = 3;
  localparam int F_SCD = 4;
  localparam int F_DIE_OT = 5;
  localparam logic [5:0] CHG_BLOCK_MASK = 6'h26;
  localparam logic [5:0] DSG_BLOCK_MASK = 6'h39;

  // Converter channel codes; cells use 0..6
  localparam logic [3:0] CH_STACK = 4'h7;
  localparam logic [3:0] CH_DIE   = 4'h8;
  localparam logic [3:0] CH_TS    = 4'h9;
  localparam logic [3:0] CH_LDO   = 4'ha;
  localparam logic [3:0] CH_VSS   = 4'hb;
  localparam logic [2:0] SHARED_SLOT = 3'h7;
  localparam logic [2:0] SHARED_LAST = 3'h4;

  typedef enum logic [0:0] {SCAN_ISSUE, SCAN_WAIT} bmi_scan_type;

endpackage
`default_nettype wire

/* File: design/bmi_measure_core.sv */
// Operation
// RULE_01: Unused cell inputs get no voltage protection.
// RULE_02: Cell results are 16-bit millivolt values.
// RULE_03: Config bit picks thermistor or analog input.
// RULE_04: Thermistor: pull-up only during conversion, LDO reference.
// RULE_05: Analog input: pull-up off, bandgap reference.
// RULE_06: Temperature pin result is raw 16-bit count.
// RULE_07: Fast filter: 24-bit result, four selectable intervals.
// RULE_08: Low power stretches every interval sixteen times.
// RULE_09: Slow filter: 16-bit current every 250ms or 4s.
// RULE_10: 48-bit charge, 16.32, plus 32-bit seconds.
// RULE_11: Host command clears charge and seconds together.
// RULE_12: Sleep holds charge and seconds unchanged.
// RULE_13: Charging current reads as positive.
// RULE_14: Die temperature converted each loop, reported; code converts it only in the shared slot of every fifth loop.
// RULE_15: Die over-limit turns FETs off, optional shutdown.
// RULE_16: Offset and gain trim before reporting, writable.
// RULE_17: Default current trim yields milliamps at 1 milliohm.
// RULE_18: Per-protection enable and autonomous FET choice.
// RULE_19: Monitor-only faults flag host; host recovers.
// RULE_20: Current faults from comparators, others from results.
// RULE_21: FET drives series or parallel, host PWM.
// RULE_22: Loop converts active cells then one shared slot.
// RULE_23: Result registers update atomically for reads.
`default_nettype none
module bmi_measure_core #(
  parameter int FAST_BASE   = bmi_pkg::FAST_BASE_CYC,
  parameter int SLOW_PERIOD = bmi_pkg::SLOW_CYC,
  parameter int SEC_PERIOD  = bmi_pkg::SECOND_CYC
) (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Avalon-MM register slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Voltage converter
  output logic             conv_req,
  output logic      [3:0]  conv_chan,
  output logic             adc_ref_ldo,
  output logic             ts_pullup_en,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_raw,
  // Coulomb counter modulator and comparators
  input  wire logic        cc_valid,
  input  wire logic        cc_bit,
  input  wire logic        occ_cmp,
  input  wire logic        ocd_cmp,
  input  wire logic        short_circuit_discharge,
  // Power mode and FET drives
  input  wire logic        sleep_mode,
  output logic             charge_fet_drive,
  output logic             discharge_fet_drive,
  output logic             shutdown_req
);
  import bmi_pkg::*;

  // ==========================================================
  // Functions
  // Offset then gain (2.14) correction of a signed raw value
  function automatic logic [15:0] trim_fn(input logic [15:0] raw,
                                          input logic [31:0] t);
    logic signed [16:0] d;
    logic signed [33:0] p;
    d = $signed({raw[15], raw}) - $signed({t[15], t[15:0]});
    p = d * $signed({1'b0, t[31:16]});
    trim_fn = p[29:14];
  endfunction

  // First used cell at or above a start index, else shared slot
  function automatic logic [2:0] next_slot(input logic [6:0] map,
                                           input logic [3:0] from);
    logic [2:0] r;
    r = SHARED_SLOT;
    for (int i = 6; i >= 0; i--) begin
      if (4'(i) >= from && map[i]) begin
        r = 3'(i);
      end
    end
    next_slot = r;
  endfunction

  // Byte-enable merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // ==========================================================
  // State
  logic [8:0]   ctrl;
  logic [6:0]   cell_map;
  logic [5:0]   prot_en;
  logic [5:0]   prot_auto;
  logic [31:0]  cell_th;
  logic [15:0]  die_th;
  logic [5:0]   fault;
  logic [31:0]  trim [0:3];
  logic [7:0]   pwm_duty;
  logic [7:0]   pwm_cnt;
  logic [15:0]  cell_v [0:6];
  logic [15:0]  stack_v;
  logic [15:0]  die_temp;
  logic [15:0]  ts_result;
  logic [15:0]  current;
  logic [23:0]  fast_raw;
  logic [23:0]  fast_sum;
  logic [31:0]  fast_cnt;
  logic [31:0]  slow_sum;
  logic [31:0]  slow_cnt;
  logic [47:0]  charge;
  logic [15:0]  charge_shadow;
  logic [31:0]  acc_time;
  logic [31:0]  sec_cnt;
  logic         ack;
  logic [2:0]   slot;
  logic [2:0]   shared_sel;
  bmi_scan_type scan_state;

  // ==========================================================
  // Bus decode: one wait cycle, answer in the next
  logic        rd_take;
  logic        wr_fire;
  logic        clear_fire;
  logic [31:0] wr_word;
  logic [31:0] view [0:31];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign rd_take    = avs_read & ~ack;
  assign wr_fire    = avs_write & ack;
  assign clear_fire = wr_fire && avs_address == REG_CMD
                      && avs_byteenable[0] && avs_writedata[0];
  assign wr_word    = merge(view[avs_address], avs_writedata,
                            avs_byteenable);

  // Read view of every word; unmapped words read zero
  always_comb begin
    for (int k = 0; k < 32; k++) begin
      view[k] = 32'h0000_0000;
    end
    view[REG_CTRL]      = {23'h0, ctrl};
    view[REG_CELL_MAP]  = {25'h0, cell_map};
    view[REG_PROT_EN]   = {26'h0, prot_en};
    view[REG_PROT_AUTO] = {26'h0, prot_auto};
    view[REG_CELL_TH]   = cell_th;
    view[REG_DIE_TH]    = {16'h0, die_th};
    view[REG_FAULT]     = {26'h0, fault};
    view[REG_PWM]       = {24'h0, pwm_duty};
    for (int k = 0; k < 4; k++) begin
      view[REG_TRIM0 + 5'(k)] = trim[k];
    end
    for (int k = 0; k < 7; k++) begin
      view[REG_CELL0 + 5'(k)] = {16'h0, cell_v[k]}; // RULE_02
    end
    view[REG_STACK]     = {16'h0, stack_v};
    view[REG_DIE_TEMP]  = {16'h0, die_temp}; // RULE_14
    view[REG_TS]        = {16'h0, ts_result};
    view[REG_CURRENT]   = {16'h0, current};
    view[REG_FAST_RAW]  = {{8{fast_raw[23]}}, fast_raw};
    view[REG_CHG_LO]    = charge[31:0];
    view[REG_CHG_HI]    = {16'h0, charge_shadow};
    view[REG_ACC_TIME]  = acc_time;
    view[REG_STATUS]    = {26'h0, shutdown_req, discharge_fet_drive,
                           charge_fet_drive, sleep_mode,
                           ctrl[CTRL_LOWPWR], conv_req};
  end

  // Acknowledge, read data and charge high-word snapshot
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack           <= 1'b0;
      avs_readdata  <= 32'h0000_0000;
      charge_shadow <= 16'h0000;
    end else if (ce) begin
      ack <= (avs_read | avs_write) & ~ack;
      if (rd_take) begin
        avs_readdata <= view[avs_address];
      end
      if (rd_take && avs_address == REG_CHG_LO) begin
        charge_shadow <= charge[47:32]; // RULE_23
      end
    end
  end

  // Configuration and trim registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl      <= CTRL_RST;
      cell_map  <= CELL_MAP_RST;
      prot_en   <= 6'h00;
      prot_auto <= 6'h00;
      cell_th   <= CELL_TH_RST;
      die_th    <= DIE_TH_RST;
      pwm_duty  <= 8'h00;
      for (int k = 0; k < 4; k++) begin
        trim[k] <= TRIM_RST; // RULE_17
      end
    end else if (ce && wr_fire) begin
      case (avs_address)
        REG_CTRL:      ctrl      <= wr_word[8:0]; // RULE_03
        REG_CELL_MAP:  cell_map  <= wr_word[6:0];
        REG_PROT_EN:   prot_en   <= wr_word[5:0]; // RULE_18
        REG_PROT_AUTO: prot_auto <= wr_word[5:0]; // RULE_18
        REG_CELL_TH:   cell_th   <= wr_word;
        REG_DIE_TH:    die_th    <= wr_word[15:0];
        REG_PWM:       pwm_duty  <= wr_word[7:0];
        default: begin
          if (avs_address[4:2] == REG_TRIM0[4:2]) begin
            trim[avs_address[1:0]] <= wr_word; // RULE_16
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Scan loop: used cells, then one rotating shared slot
  logic       slot_ok;
  logic       is_ts;
  logic [5:0] ev;
  logic [15:0] cell_new;
  assign slot_ok  = slot == SHARED_SLOT || cell_map[slot]; // RULE_01
  assign conv_req = scan_state == SCAN_ISSUE && slot_ok;
  assign conv_chan = (slot != SHARED_SLOT) ? {1'b0, slot} :
                     (shared_sel == 3'h0) ? CH_DIE :
                     (shared_sel == 3'h1) ? CH_TS :
                     (shared_sel == 3'h2) ? CH_STACK :
                     (shared_sel == 3'h3) ? CH_LDO : CH_VSS;
  assign is_ts        = conv_chan == CH_TS;
  assign adc_ref_ldo  = is_ts && !ctrl[CTRL_GENERAL_ANALOG_INPUT]; // RULE_04 RULE_05
  assign ts_pullup_en = is_ts && !ctrl[CTRL_GENERAL_ANALOG_INPUT]
                        && scan_state == SCAN_WAIT; // RULE_04 RULE_05
  assign cell_new = trim_fn(conv_raw, trim[TRIM_CELL]);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      scan_state <= SCAN_ISSUE;
      slot       <= 3'h0;
      shared_sel <= 3'h0;
      stack_v    <= 16'h0000;
      die_temp   <= 16'h0000;
      ts_result  <= 16'h0000;
      for (int k = 0; k < 7; k++) begin
        cell_v[k] <= 16'h0000;
      end
    end else if (ce) begin
      case (scan_state)
        SCAN_ISSUE: begin
          if (slot_ok) begin
            scan_state <= SCAN_WAIT;
          end else begin
            slot <= next_slot(cell_map, {1'b0, slot} + 4'h1);
          end
        end
        SCAN_WAIT: begin
          if (conv_done) begin
            scan_state <= SCAN_ISSUE;
            if (slot == SHARED_SLOT) begin // RULE_22
              shared_sel <= (shared_sel == SHARED_LAST) ? 3'h0
                            : shared_sel + 3'h1;
              slot <= next_slot(cell_map, 4'h0);
            end else begin
              slot <= next_slot(cell_map, {1'b0, slot} + 4'h1);
              cell_v[slot] <= cell_new; // RULE_02 RULE_16
            end
            if (conv_chan == CH_STACK) begin
              stack_v <= trim_fn(conv_raw, trim[TRIM_STACK]);
            end
            if (conv_chan == CH_DIE) begin
              die_temp <= trim_fn(conv_raw, trim[TRIM_DIE]); // RULE_14
            end
            if (is_ts) begin
              ts_result <= conv_raw; // RULE_06
            end
          end
        end
        default: scan_state <= SCAN_ISSUE;
      endcase
    end
  end

  // ==========================================================
  // Protection events, sticky fault flags (set beats clear)
  logic       cell_done;
  logic [5:0] fault_clr;
  // Write-one-to-clear acts only on an enabled byte lane
  assign fault_clr = avs_byteenable[0] ? avs_writedata[5:0] : 6'h00;
  assign cell_done = scan_state == SCAN_WAIT && conv_done
                     && slot != SHARED_SLOT && cell_map[slot]; // RULE_01
  assign ev[F_UV] = prot_en[F_UV] && cell_done
                    && $signed(cell_new) < $signed(cell_th[31:16]);
  assign ev[F_OV] = prot_en[F_OV] && cell_done
                    && $signed(cell_new) > $signed(cell_th[15:0]);
  assign ev[F_OCC] = prot_en[F_OCC] && occ_cmp; // RULE_20
  assign ev[F_OCD] = prot_en[F_OCD] && ocd_cmp; // RULE_20
  assign ev[F_SCD] = prot_en[F_SCD] && short_circuit_discharge;
  assign ev[F_DIE_OT] = prot_en[F_DIE_OT] && scan_state == SCAN_WAIT
      && conv_done && conv_chan == CH_DIE
      && $signed(trim_fn(conv_raw, trim[TRIM_DIE]))
         > $signed(die_th); // RULE_15

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fault        <= 6'h00;
      shutdown_req <= 1'b0;
    end else if (ce) begin
      if (wr_fire && avs_address == REG_FAULT) begin
        fault <= (fault & ~fault_clr) | ev; // RULE_19
      end else begin
        fault <= fault | ev; // RULE_19
      end
      if (ev[F_DIE_OT] && ctrl[CTRL_OT_SHDN]) begin
        shutdown_req <= 1'b1; // RULE_15
      end
    end
  end

  // ==========================================================
  // FET drives: host enables, PWM, autonomous fault blocking
  logic [5:0] auto_f;
  logic       block_chg;
  logic       block_dsg;
  logic       pwm_on;
  assign auto_f    = fault & prot_auto; // RULE_18
  assign block_chg = ctrl[CTRL_PARALLEL] ? |(auto_f & CHG_BLOCK_MASK)
                                         : |auto_f; // RULE_21
  assign block_dsg = ctrl[CTRL_PARALLEL] ? |(auto_f & DSG_BLOCK_MASK)
                                         : |auto_f; // RULE_21
  assign pwm_on    = !ctrl[CTRL_PWM_EN] || pwm_cnt < pwm_duty;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwm_cnt             <= 8'h00;
      charge_fet_drive    <= 1'b0;
      discharge_fet_drive <= 1'b0;
    end else if (ce) begin
      pwm_cnt <= pwm_cnt + 8'h01;
      charge_fet_drive <= ctrl[CTRL_CHG_ON] && pwm_on
                          && !block_chg && !shutdown_req; // RULE_15
      discharge_fet_drive <= ctrl[CTRL_DSG_ON] && pwm_on
                             && !block_dsg && !shutdown_req; // RULE_21
    end
  end

  // ==========================================================
  // Coulomb counter filters, charge and seconds integration
  logic        lp;
  logic [31:0] fast_ival;
  logic [31:0] slow_ival;
  logic [15:0] cur_new;
  logic [47:0] cur_ext;
  logic [47:0] charge_inc;
  logic        slow_end;
  assign lp        = ctrl[CTRL_LOWPWR];
  assign fast_ival = 32'(FAST_BASE) << ({3'h0, ctrl[2:1]}
                     + (lp ? 5'(LP_SHIFT) : 5'h00)); // RULE_07 RULE_08
  assign slow_ival = lp ? (32'(SLOW_PERIOD) << LP_SHIFT)
                        : 32'(SLOW_PERIOD); // RULE_09
  assign slow_end  = slow_cnt >= slow_ival - 32'h1;
  assign cur_new   = trim_fn(slow_sum[SLOW_SHIFT +: 16],
                             trim[TRIM_CUR]); // RULE_16 RULE_17
  assign cur_ext   = {{32{cur_new[15]}}, cur_new};
  assign charge_inc = lp ? (cur_ext << 34) : (cur_ext << 30);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fast_cnt <= 32'h0;
      fast_sum <= 24'h0;
      fast_raw <= 24'h0;
      slow_cnt <= 32'h0;
      slow_sum <= 32'h0;
      current  <= 16'h0;
    end else if (ce) begin
      // Positive bit means sense_input_pos above sense_input_neg
      if (fast_cnt >= fast_ival - 32'h1) begin
        fast_raw <= fast_sum; // RULE_07
        fast_sum <= 24'h0;
        fast_cnt <= 32'h0;
      end else begin
        fast_cnt <= fast_cnt + 32'h1;
        if (cc_valid) begin
          fast_sum <= cc_bit ? fast_sum + 24'h1
                             : fast_sum - 24'h1; // RULE_13
        end
      end
      if (slow_end) begin
        current  <= cur_new; // RULE_09
        slow_sum <= 32'h0;
        slow_cnt <= 32'h0;
      end else begin
        slow_cnt <= slow_cnt + 32'h1;
        if (cc_valid) begin
          slow_sum <= cc_bit ? slow_sum + 32'h1
                             : slow_sum - 32'h1; // RULE_13
        end
      end
    end
  end

  // Passed charge (16.32) and elapsed seconds
  always_ff @(posedge core_clk) begin
    if (srst) begin
      charge   <= 48'h0;
      acc_time <= 32'h0;
      sec_cnt  <= 32'h0;
    end else if (ce) begin
      if (clear_fire) begin
        charge   <= 48'h0; // RULE_11
        acc_time <= 32'h0; // RULE_11
        sec_cnt  <= 32'h0;
      end else if (!sleep_mode) begin // RULE_12
        if (slow_end) begin
          charge <= charge + charge_inc; // RULE_10
        end
        if (sec_cnt >= 32'(SEC_PERIOD) - 32'h1) begin
          sec_cnt  <= 32'h0;
          acc_time <= acc_time + 32'h1; // RULE_10
        end else begin
          sec_cnt <= sec_cnt + 32'h1;
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  unused_cell_a: assert property ( // RULE_01
    conv_req && conv_chan < CH_STACK |-> cell_map[conv_chan[2:0]])
    else $error("conversion issued for an unused cell");
  ts_pullup_a: assert property ( // RULE_04
    ts_pullup_en |-> conv_chan == CH_TS && adc_ref_ldo
                     && scan_state == SCAN_WAIT)
    else $error("pull-up on outside thermistor conversion");
  general_analog_input_ref_a: assert property ( // RULE_05
    ctrl[CTRL_GENERAL_ANALOG_INPUT] |-> !ts_pullup_en && !adc_ref_ldo)
    else $error("analog input mode uses pull-up or LDO reference");
  clear_cmd_a: assert property ( // RULE_11
    ce && clear_fire |=> charge == 48'h0 && acc_time == 32'h0)
    else $error("clear command did not zero charge and time");
  sleep_hold_a: assert property ( // RULE_12
    ce && sleep_mode && !clear_fire |=> $stable(charge)
                                        && $stable(acc_time))
    else $error("charge or time moved during sleep");
  fet_block_a: assert property ( // RULE_15
    ce && ev[F_DIE_OT] && prot_auto[F_DIE_OT]
    |=> ##1 !charge_fet_drive && !discharge_fet_drive)
    else $error("die overtemperature left a FET on");
  charge_snap_a: assert property ( // RULE_23
    ce && rd_take && avs_address == REG_CHG_LO
    |=> charge_shadow == $past(charge[47:32]))
    else $error("charge high word not captured with low word");
  fast_bound_a: assert property ( // RULE_07
    fast_cnt < fast_ival || $changed(ctrl))
    else $error("fast filter interval overrun");
  fault_sticky_a: assert property ( // RULE_19
    ce && |fault && !(wr_fire && avs_address == REG_FAULT)
    |=> (fault & $past(fault)) == $past(fault))
    else $error("fault flag dropped without host clear");

endmodule
`default_nettype wire

/* File: test/bmi_conv_model.sv */
`default_nettype none
// ==========
// Converter on the far side of the scan loop
module bmi_conv_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Conversion handshake
  input  wire logic        conv_req,
  input  wire logic [3:0]  conv_chan,
  input  wire logic [15:0] die_raw,
  output logic             conv_done,
  output logic      [15:0] conv_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  import bmi_pkg::*;
  logic       busy = 1'b0;
  logic       slow = 1'b0;
  logic [2:0] cnt  = 3'h0;
  wire        fin  = busy && cnt == 3'h0;
  // Answers alternate fast and slow; data scrambles outside the strobe
  always @(posedge core_clk) begin
    conv_done <= fin && !srst;
    conv_raw  <= srst ? 16'h0000 : fin ?
                 (conv_chan == CH_DIE ? die_raw : {4'h1, conv_chan, 8'h3c}) :
                 conv_raw ^ 16'ha5a5;
    if (srst || fin) busy <= 1'b0;
    else if (!busy && conv_req && !conv_done) begin
      busy <= 1'b1;
      cnt  <= slow ? 3'h6 : 3'h1;
      slow <= ~slow;
    end else if (busy) cnt <= cnt - 3'h1;
  end
endmodule
`default_nettype wire

/* File: test/test_battery_measurement_integrator.sv */
`default_nettype none
module test_battery_measurement_integrator;
  timeunit 1ns;
  timeprecision 1ns;
  import bmi_pkg::*;
  // ==========
  // Stimulus and observed signals
  logic core_clk = 1'b0, srst = 1'b1, ce = 1'b1, sleep_mode = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, cc_valid = 1'b0, cc_bit = 1'b0;
  logic occ_cmp = 1'b0, ocd_cmp = 1'b0, short_circuit_discharge = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, t1;
  logic [3:0]  avs_byteenable = 4'hf, conv_chan;
  logic [15:0] conv_raw, die_raw = 16'h0100;
  logic avs_waitrequest, conv_req, adc_ref_ldo, ts_pullup_en, conv_done;
  logic charge_fet_drive, discharge_fet_drive, shutdown_req;
  logic [31:0] mdl [32];
  logic [4:0]  ra [9] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0a,
                          5'h0b, 5'h0d};
  int          error_cnt = 0;
  int          compares = 0;
  integer      seed = 32'h55ee1580;
  always #5 core_clk = ~core_clk;
  bmi_measure_core #(.FAST_BASE(8), .SLOW_PERIOD(64), .SEC_PERIOD(100)) dut (
    .core_clk(core_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_req(conv_req), .conv_chan(conv_chan), .adc_ref_ldo(adc_ref_ldo),
    .ts_pullup_en(ts_pullup_en), .conv_done(conv_done), .conv_raw(conv_raw),
    .cc_valid(cc_valid), .cc_bit(cc_bit), .occ_cmp(occ_cmp),
    .ocd_cmp(ocd_cmp), .short_circuit_discharge(short_circuit_discharge),
    .sleep_mode(sleep_mode), .charge_fet_drive(charge_fet_drive),
    .discharge_fet_drive(discharge_fet_drive), .shutdown_req(shutdown_req));
  bmi_conv_model conv (.core_clk(core_clk), .srst(srst), .conv_req(conv_req),
    .conv_chan(conv_chan), .die_raw(die_raw), .conv_done(conv_done),
    .conv_raw(conv_raw));
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Mismatches %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Avalon cycle; model copy follows after the accepting edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(negedge core_clk);
    if (wr) mdl[a] = d & (a == REG_CTRL ? 32'h1ff : a == REG_CELL_MAP ?
                          32'h7f : 32'h0);
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Modulator samples, mostly charging
  always @(posedge core_clk) begin
    cc_valid <= 1'($random(seed));
    cc_bit   <= ($random(seed) & 3) != 0;
  end
  // Scan loop monitor
  always @(posedge core_clk) begin
    if (!srst && conv_req && conv_chan < 4'h7)
      chk({31'h0, mdl[REG_CELL_MAP][conv_chan]}, 32'h1);
    if (!srst && ce && conv_done) begin
      chk({31'h0, ts_pullup_en}, {31'h0, conv_chan == CH_TS &&
          !mdl[REG_CTRL][CTRL_GENERAL_ANALOG_INPUT]});
      if (conv_chan == CH_TS)
        chk({31'h0, adc_ref_ldo}, {31'h0, !mdl[REG_CTRL][CTRL_GENERAL_ANALOG_INPUT]});
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    wrap_up;
  end
  // ==========
  // Main sequence
  initial begin
    foreach (mdl[i]) mdl[i] = (i >= 8 && i < 12) ? TRIM_RST : 32'h0;
    mdl[REG_CELL_MAP] = {25'h0, CELL_MAP_RST};
    mdl[REG_CELL_TH] = CELL_TH_RST;
    mdl[REG_DIE_TH] = {16'h0, DIE_TH_RST};
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    foreach (ra[i]) rdchk(ra[i], mdl[ra[i]]);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, REG_CELL_MAP, 32'($random(seed)) | 32'h41);
      bus(1'b1, REG_CTRL, {23'h0, 9'($random(seed)) & 9'h1f7});
      rdchk(REG_CTRL, mdl[REG_CTRL]);
      rdchk(REG_CELL_MAP, mdl[REG_CELL_MAP]);
      repeat (400) @(posedge core_clk);
      rdchk(REG_TS, 32'h0000_193c);
      rdchk(REG_CELL0, 32'h0000_103c);
      rdchk(REG_STACK, 32'h0000_173c);
      rdchk(REG_DIE_TEMP, 32'h0000_0100);
    end
    bus(1'b1, REG_CTRL, 32'h0000_00d0);
    bus(1'b1, REG_PROT_EN, 32'h0000_000c);
    bus(1'b1, REG_PROT_AUTO, 32'h0000_0004);
    repeat (5) @(posedge core_clk);
    chk({30'h0, charge_fet_drive, discharge_fet_drive}, 32'h3);
    occ_cmp <= 1'b1;
    ocd_cmp <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk({30'h0, charge_fet_drive, discharge_fet_drive}, 32'h1);
    rdchk(REG_FAULT, 32'h0000_000c);
    occ_cmp <= 1'b0;
    ocd_cmp <= 1'b0;
    bus(1'b1, REG_FAULT, 32'h0000_003f);
    rdchk(REG_FAULT, 32'h0);
    repeat (5) @(posedge core_clk);
    chk({30'h0, charge_fet_drive, discharge_fet_drive}, 32'h3);
    bus(1'b1, REG_CMD, 32'h1);
    rdchk(REG_ACC_TIME, 32'h0);
    repeat (350) @(posedge core_clk);
    bus(1'b0, REG_ACC_TIME, 32'h0);
    chk({31'h0, rd inside {32'h3, 32'h4}}, 32'h1);
    bus(1'b0, REG_CURRENT, 32'h0);
    chk({31'h0, rd[15]}, 32'h0);
    sleep_mode <= 1'b1;
    bus(1'b0, REG_ACC_TIME, 32'h0);
    t1 = rd;
    repeat (300) @(posedge core_clk);
    rdchk(REG_ACC_TIME, t1);
    sleep_mode <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h0000_00e0);
    bus(1'b1, REG_PROT_EN, 32'h0000_0020);
    bus(1'b1, REG_PROT_AUTO, 32'h0000_0020);
    die_raw <= 16'h7000;
    repeat (400) @(posedge core_clk);
    chk({29'h0, shutdown_req, charge_fet_drive, discharge_fet_drive},
        32'h4);
    // Clock enable low must freeze the seconds count
    bus(1'b0, REG_ACC_TIME, 32'h0);
    t1 = rd;
    ce <= 1'b0;
    repeat (250) @(posedge core_clk);
    ce <= 1'b1;
    bus(1'b0, REG_ACC_TIME, 32'h0);
    chk({31'h0, rd - t1 < 32'h2}, 32'h1);
    wrap_up;
  end
endmodule
`default_nettype wire
